// file: dup_record.sv
/*
 * Record of recently seen message identifiers, searched in parallel.
 * Assumes one clock and synchronous active-high reset; DEPTH at least 2.
 */
module dup_record #(
	parameter int DEPTH = 8,
	parameter int ID_W = 16
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// lookup
	input wire logic [ID_W-1:0] query_id_i,
	output logic hit_o,
	// record a new identifier
	input wire logic insert_i,
	input wire logic [ID_W-1:0] insert_id_i
);
	localparam int PW = $clog2(DEPTH);

	logic [ID_W-1:0] id_r [DEPTH];
	logic [DEPTH-1:0] used_r;
	logic [DEPTH-1:0] match;
	logic [PW-1:0] ptr_r;

	// parallel compare against every live entry
	for (genvar g = 0; g < DEPTH; g++) begin : g_cmp
		assign match[g] = used_r[g] & (id_r[g] == query_id_i);
	end
	assign hit_o = |match;

	// identifier storage
	always_ff @(posedge clk_i) begin
		if (insert_i) begin
			id_r[ptr_r] <= insert_id_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			used_r <= '0;
			ptr_r <= '0;
		end else if (insert_i) begin
			used_r[ptr_r] <= 1'b1;
			ptr_r <= (ptr_r == PW'(DEPTH-1)) ? '0 : ptr_r + 1'b1;
		end
	end
endmodule : dup_record

// file: peer_model.sv
/*
 * Other modems of the group: sends queued frames into the receive stream
 * and collects the outgoing stream, stalling it on request.
 * Assumes the bench fills tx_q and reads got_q hierarchically.
 */
module peer_model (
	// clock
	input wire logic clk_i,
	// frames towards the filter
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	output logic rx_last_o,
	input wire logic rx_ready_i,
	// frames from the filter
	input wire logic out_valid_i,
	input wire logic [7:0] out_data_i,
	input wire logic out_last_i,
	input wire logic out_relay_i,
	output logic out_ready_o,
	input wire logic stall_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [8:0] tx_q[$];
	logic [9:0] got_q[$];

	// idle lines at start
	initial begin
		rx_valid_o = 1'b0;
		rx_data_o = 8'h00;
		rx_last_o = 1'b0;
		out_ready_o = 1'b0;
	end
	always @(posedge clk_i) begin
		if (rx_valid_o && rx_ready_i) begin
			void'(tx_q.pop_front());
		end
		if (tx_q.size() > 0) begin
			rx_valid_o <= 1'b1;
			{rx_last_o, rx_data_o} <= tx_q[0];
		end else begin
			rx_valid_o <= 1'b0;
			rx_data_o <= ~rx_data_o;
		end
		if (out_valid_i && out_ready_o) begin
			got_q.push_back({out_relay_i, out_last_i, out_data_i});
		end
		out_ready_o <= !stall_i;
	end
endmodule : peer_model

// file: radio_repeater_relay_filter.sv
/*
 * Receive filter and relay path of a radio modem: header check, duplicate
 * suppression, buffering, listen-before-talk and alarm origination, with a
 * classic Wishbone register file.
 * Assumes received bytes arrive as a valid/ready stream framed by a last flag,
 * header bytes group, target, source, sequence; one clock, synchronous reset.
 */
// Operation
// - A repeater sends on each accepted message byte for byte, untouched.
// - A repeater serves one group and relays only messages of that group.
// - A repeater records each relayed message and drops later copies of it; the record holds only the last DUP_DEPTH messages.
// - Broadcast-addressed messages of the group are relayed like any other.
// - A repeater drops every message carrying group zero.
// - Every unit drops received messages already in its record.
// - In repeater mode the own unit number goes only into originated alarms and lies in 1 to 254; the code does not check it on entry to repeater mode.
// - A repeater never originates data, so the target setting has no effect.
// - In repeater mode the group setting takes only 1 to 254, never zero.
// - The repeater protocol matches its network and is never the ARQ packet one.
// - The protocol setting may change only in data-only or repeater mode.
// - Transmission waits while the channel is busy unless hold-off allows any time.
// - Non-repeaters with group zero take every message not in the record; repeaters refuse group zero.
module radio_repeater_relay_filter #(
	parameter int FIFO_DEPTH = 4,
	parameter int DUP_DEPTH = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// received message stream
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_last_i,
	output logic rx_ready_o,
	// channel and alarm
	input wire logic carrier_busy_i,
	input wire logic alarm_req_i,
	input wire logic [7:0] alarm_code_i,
	// outgoing message stream
	output logic out_valid_o,
	output logic [7:0] out_data_o,
	output logic out_last_o,
	output logic out_relay_o,
	input wire logic out_ready_i
);
	typedef enum logic [1:0] {RX_HDR, RX_PUSH, RX_PASS, RX_DROP} rx_state_t;
	typedef enum logic [1:0] {OUT_IDLE, OUT_MSG, OUT_ALARM} out_state_t;

	// ==========================================================
	// declarations
	logic [1:0] mode_r;
	logic [1:0] proto_r;
	logic hold_any_r;
	logic [7:0] group_r;
	logic [7:0] source_r;
	logic [7:0] target_r;
	logic reject_r;
	logic [15:0] accepted_r;
	logic [15:0] dropped_r;
	logic ack_r;
	logic [31:0] dat_r;
	logic [31:0] rd_mux;
	logic wr_en;
	logic [1:0] new_mode;
	logic [1:0] new_proto;
	logic proto_bad;
	logic mode_bad;
	logic group_bad;
	logic source_bad;

	logic hold_valid_r;
	logic [7:0] hold_data_r;
	logic hold_last_r;
	logic rx_ready_r;
	logic take;
	rx_state_t rx_state_r;
	logic [7:0] hdr_r [4];
	logic [1:0] idx_r;
	logic hdr_last_r;
	logic repeater;
	logic accept;
	logic dup_hit;
	logic record;

	logic fifo_in_valid;
	logic [8:0] fifo_in_data;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [8:0] fifo_out_data;
	logic fifo_out_ready;

	out_state_t out_state_r;
	logic out_valid_r;
	logic [7:0] out_data_r;
	logic out_last_r;
	logic out_relay_r;
	logic load_slot;
	logic need_wait;
	logic defer_r;
	logic alarm_pend_r;
	logic [7:0] alarm_code_r;
	logic [7:0] alarm_seq_r;
	logic [2:0] alarm_idx_r;
	logic [7:0] alarm_byte;

	assign repeater = (mode_r == relay_pkg::MODE_REPEATER);

	// ==========================================================
	// wishbone slave
	assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ack_r & wb_sel_i[0];
	assign new_mode = wb_dat_i[relay_pkg::CTRL_MODE_LSB +: 2];
	assign new_proto = wb_dat_i[relay_pkg::CTRL_PROTO_LSB +: 2];

	assign proto_bad = (new_proto != proto_r) & (mode_r != relay_pkg::MODE_DATA) & ~repeater;
	// no ARQ protocol, no open group in repeater
	assign mode_bad = (new_mode == relay_pkg::MODE_REPEATER) &
		(((proto_bad ? proto_r : new_proto) == relay_pkg::PROTO_PACKET_ARQ) |
		(group_r == relay_pkg::GROUP_OPEN));
	assign group_bad = (wb_dat_i[7:0] == relay_pkg::UNIT_BROADCAST) |
		(repeater & (wb_dat_i[7:0] == relay_pkg::GROUP_OPEN));
	assign source_bad = (wb_dat_i[7:0] > relay_pkg::UNIT_MAX) |
		(repeater & (wb_dat_i[7:0] < relay_pkg::UNIT_MIN));

	// read data selection, unmapped reads as zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (wb_adr_i)
			relay_pkg::REG_CTRL: rd_mux = {27'h0, hold_any_r, proto_r, mode_r};
			relay_pkg::REG_GROUP: rd_mux = {24'h0, group_r};
			relay_pkg::REG_SOURCE: rd_mux = {24'h0, source_r};
			relay_pkg::REG_TARGET: rd_mux = {24'h0, target_r};
			relay_pkg::REG_STATUS: rd_mux = {29'h0, (rx_state_r != RX_HDR), defer_r, reject_r};
			relay_pkg::REG_ACCEPTED: rd_mux = {16'h0, accepted_r};
			relay_pkg::REG_DROPPED: rd_mux = {16'h0, dropped_r};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// one-wait-state acknowledge with registered read data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else begin
			ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
			dat_r <= rd_mux;
		end
	end
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	// configuration registers, refused values keep the old setting
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_r <= relay_pkg::RST_MODE;
			proto_r <= relay_pkg::RST_PROTO;
			hold_any_r <= relay_pkg::RST_HOLD;
			group_r <= relay_pkg::RST_GROUP;
			source_r <= relay_pkg::RST_SOURCE;
			target_r <= relay_pkg::RST_TARGET;
		end else if (wr_en) begin
			case (wb_adr_i)
				relay_pkg::REG_CTRL: begin
					hold_any_r <= wb_dat_i[relay_pkg::CTRL_HOLD_BIT];
					if (!proto_bad && !(repeater && new_proto == relay_pkg::PROTO_PACKET_ARQ)) begin
						proto_r <= new_proto;
					end
					if (!mode_bad) begin
						mode_r <= new_mode;
					end
				end
				relay_pkg::REG_GROUP: begin
					if (!group_bad) begin
						group_r <= wb_dat_i[7:0];
					end
				end
				relay_pkg::REG_SOURCE: begin
					if (!source_bad) begin
						source_r <= wb_dat_i[7:0];
					end
				end
				relay_pkg::REG_TARGET: target_r <= wb_dat_i[7:0];
				default: ;
			endcase
		end
	end

	// sticky refusal flag, a new refusal wins over the clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reject_r <= 1'b0;
		end else if (wr_en && (((wb_adr_i == relay_pkg::REG_CTRL) &&
			(proto_bad || mode_bad || (repeater && new_proto == relay_pkg::PROTO_PACKET_ARQ))) ||
			((wb_adr_i == relay_pkg::REG_GROUP) && group_bad) ||
			((wb_adr_i == relay_pkg::REG_SOURCE) && source_bad))) begin
			reject_r <= 1'b1;
		end else if (wr_en && (wb_adr_i == relay_pkg::REG_STATUS) &&
			wb_dat_i[relay_pkg::STAT_REJECT_BIT]) begin
			reject_r <= 1'b0;
		end
	end

	// ==========================================================
	// receive holding register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_valid_r <= 1'b0;
			hold_data_r <= 8'h00;
			hold_last_r <= 1'b0;
			rx_ready_r <= 1'b0;
		end else begin
			if (rx_valid_i && rx_ready_r) begin
				hold_valid_r <= 1'b1;
				hold_data_r <= rx_data_i;
				hold_last_r <= rx_last_i;
			end else if (take) begin
				hold_valid_r <= 1'b0;
			end
			rx_ready_r <= ~((hold_valid_r & ~take) | (rx_valid_i & rx_ready_r));
		end
	end
	assign rx_ready_o = rx_ready_r;

	// ==========================================================
	// acceptance decision on the sequence byte
	always_comb begin
		if (repeater) begin
			accept = (hdr_r[relay_pkg::HDR_GROUP] == group_r) &
				(hdr_r[relay_pkg::HDR_GROUP] != relay_pkg::GROUP_OPEN);
		end else if (group_r == relay_pkg::GROUP_OPEN) begin
			accept = 1'b1;
		end else begin
			accept = (hdr_r[relay_pkg::HDR_GROUP] == relay_pkg::GROUP_OPEN) |
				((hdr_r[relay_pkg::HDR_GROUP] == group_r) &
				((hdr_r[relay_pkg::HDR_TARGET] == source_r) |
				(hdr_r[relay_pkg::HDR_TARGET] == relay_pkg::UNIT_BROADCAST)));
		end
		accept = accept & ~dup_hit;
	end
	assign record = take & (rx_state_r == RX_HDR) & (idx_r == relay_pkg::HDR_SEQ) & accept;

	dup_record #(
		.DEPTH(DUP_DEPTH),
		.ID_W(16)
	) u_dup (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.query_id_i({hdr_r[relay_pkg::HDR_SOURCE], hold_data_r}),
		.hit_o(dup_hit),
		.insert_i(record),
		.insert_id_i({hdr_r[relay_pkg::HDR_SOURCE], hold_data_r})
	);

	// ==========================================================
	// receive sequencing
	always_comb begin
		case (rx_state_r)
			RX_HDR, RX_DROP: take = hold_valid_r;
			RX_PASS: take = hold_valid_r & fifo_in_ready;
			default: take = 1'b0;
		endcase
	end

	assign fifo_in_valid = (rx_state_r == RX_PUSH) | ((rx_state_r == RX_PASS) & hold_valid_r);
	assign fifo_in_data = (rx_state_r == RX_PUSH) ?
		{(idx_r == relay_pkg::HDR_SEQ) & hdr_last_r, hdr_r[idx_r]} : {hold_last_r, hold_data_r};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_state_r <= RX_HDR;
			idx_r <= 2'h0;
			hdr_last_r <= 1'b0;
			accepted_r <= 16'h0000;
			dropped_r <= 16'h0000;
		end else begin
			case (rx_state_r)
				RX_HDR: begin
					if (take) begin
						hdr_r[idx_r] <= hold_data_r;
						idx_r <= 2'h0;
						if (idx_r == relay_pkg::HDR_SEQ) begin
							hdr_last_r <= hold_last_r;
							if (accept) begin
								rx_state_r <= RX_PUSH;
								accepted_r <= accepted_r + 1'b1;
							end else begin
								rx_state_r <= hold_last_r ? RX_HDR : RX_DROP;
								dropped_r <= dropped_r + 1'b1;
							end
						end else if (hold_last_r) begin
							dropped_r <= dropped_r + 1'b1;
						end else begin
							idx_r <= idx_r + 1'b1;
						end
					end
				end
				RX_PUSH: begin
					if (fifo_in_ready) begin
						idx_r <= idx_r + 1'b1;
						if (idx_r == relay_pkg::HDR_SEQ) begin
							rx_state_r <= hdr_last_r ? RX_HDR : RX_PASS;
						end
					end
				end
				RX_PASS, RX_DROP: begin
					if (take && hold_last_r) begin
						rx_state_r <= RX_HDR;
					end
				end
				default: rx_state_r <= RX_HDR;
			endcase
		end
	end

	stream_fifo #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(fifo_in_valid),
		.in_data_i(fifo_in_data),
		.in_ready_o(fifo_in_ready),
		.out_valid_o(fifo_out_valid),
		.out_data_o(fifo_out_data),
		.out_ready_i(fifo_out_ready)
	);

	// ==========================================================
	// alarm origination
	always_comb begin
		case (alarm_idx_r)
			3'h0: alarm_byte = group_r;
			3'h1: alarm_byte = relay_pkg::UNIT_BROADCAST;
			3'h2: alarm_byte = source_r;
			3'h3: alarm_byte = alarm_seq_r;
			default: alarm_byte = alarm_code_r;
		endcase
	end

	// ==========================================================
	// output stage
	assign load_slot = ~out_valid_r | out_ready_i;
	assign fifo_out_ready = (out_state_r == OUT_MSG) & load_slot;
	assign need_wait = ~hold_any_r & carrier_busy_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_state_r <= OUT_IDLE;
			out_valid_r <= 1'b0;
			out_data_r <= 8'h00;
			out_last_r <= 1'b0;
			out_relay_r <= 1'b0;
			alarm_pend_r <= 1'b0;
			alarm_code_r <= 8'h00;
			alarm_seq_r <= 8'h00;
			alarm_idx_r <= 3'h0;
			defer_r <= 1'b0;
		end else begin
			if (alarm_req_i) begin
				alarm_pend_r <= 1'b1;
				alarm_code_r <= alarm_code_i;
			end
			defer_r <= (out_state_r == OUT_IDLE) & need_wait &
				(alarm_pend_r | (fifo_out_valid & repeater));
			if (load_slot) begin
				out_valid_r <= 1'b0;
			end
			case (out_state_r)
				OUT_IDLE: begin
					if (!out_valid_r && alarm_pend_r && !need_wait) begin // idle gap after a frame
						out_state_r <= OUT_ALARM;
						alarm_idx_r <= 3'h0;
						if (!alarm_req_i) begin
							alarm_pend_r <= 1'b0;
						end
					end else if (!out_valid_r && fifo_out_valid && !(repeater && need_wait)) begin
						out_state_r <= OUT_MSG;
					end
				end
				OUT_MSG: begin
					if (fifo_out_valid && load_slot) begin
						out_valid_r <= 1'b1;
						out_data_r <= fifo_out_data[7:0];
						out_last_r <= fifo_out_data[8];
						out_relay_r <= repeater;
						if (fifo_out_data[8]) begin
							out_state_r <= OUT_IDLE;
						end
					end
				end
				OUT_ALARM: begin
					if (load_slot) begin
						out_valid_r <= 1'b1;
						out_data_r <= alarm_byte;
						out_last_r <= (alarm_idx_r == relay_pkg::ALARM_CODE_IDX);
						out_relay_r <= 1'b1;
						alarm_idx_r <= alarm_idx_r + 1'b1;
						if (alarm_idx_r == relay_pkg::ALARM_CODE_IDX) begin
							out_state_r <= OUT_IDLE;
							alarm_seq_r <= alarm_seq_r + 1'b1;
						end
					end
				end
				default: out_state_r <= OUT_IDLE;
			endcase
		end
	end

	assign out_valid_o = out_valid_r;
	assign out_data_o = out_data_r;
	assign out_last_o = out_last_r;
	assign out_relay_o = out_relay_r;
endmodule : radio_repeater_relay_filter

// file: radio_repeater_relay_filter_checker.sv
/*
 * Port checker of the relay filter, bound into its top module.
 * Assumes one clock and a synchronous active-high reset.
 */
module radio_repeater_relay_filter_checker (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// streams and channel
	input wire logic rx_ready_o,
	input wire logic carrier_busy_i,
	input wire logic out_valid_o,
	input wire logic [7:0] out_data_o,
	input wire logic out_last_o,
	input wire logic out_relay_o,
	input wire logic out_ready_i
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	logic hold_r;
	logic rd_ack;

	// ====================
	// shadow of the hold-off flag, stored by every control write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_r <= relay_pkg::RST_HOLD;
		end else if (wb_ack_o && wb_we_i && wb_adr_i == relay_pkg::REG_CTRL) begin
			hold_r <= wb_dat_i[relay_pkg::CTRL_HOLD_BIT];
		end
	end
	// read answer on the bus
	assign rd_ack = wb_ack_o && !wb_we_i;

	// ====================
	// bus handshake and register ranges
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request unanswered");
	chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	chk_reset_quiet: assert property ($fell(rst_i)
		|-> !wb_ack_o && !out_valid_o && !rx_ready_o && wb_dat_o == 32'h0) else $error("busy after reset");
	chk_group_range: assert property (rd_ack && wb_adr_i == relay_pkg::REG_GROUP
		|-> wb_dat_o[31:8] == 24'h0 && wb_dat_o[7:0] != relay_pkg::UNIT_BROADCAST) else $error("bad group");
	chk_source_range: assert property (rd_ack && wb_adr_i == relay_pkg::REG_SOURCE
		|-> wb_dat_o <= {24'h0, relay_pkg::UNIT_MAX}) else $error("bad source");
	chk_count_width: assert property (rd_ack |-> wb_dat_o[31:16] == 16'h0)
		else $error("upper bits set");
	// output stream
	chk_out_hold: assert property (out_valid_o && !out_ready_i
		|=> out_valid_o && $stable(out_data_o) && $stable(out_last_o)) else $error("byte changed in stall");
	chk_msg_gap: assert property (out_valid_o && out_ready_i && out_last_o |=> !out_valid_o)
		else $error("no gap after frame");
	chk_carrier_defer: assert property ($rose(out_valid_o) && out_relay_o && !hold_r && !$past(hold_r)
		|-> !($past(carrier_busy_i) && $past(carrier_busy_i, 2))) else $error("sent on busy channel");
	// main scenarios
	cov_relay: cover property (out_valid_o && out_ready_i && out_relay_o && out_last_o);
	cov_stall: cover property ((out_valid_o && !out_ready_i) [*4]);
	cov_write: cover property (wb_ack_o && wb_we_i);
endmodule : radio_repeater_relay_filter_checker

bind radio_repeater_relay_filter radio_repeater_relay_filter_checker u_radio_repeater_relay_filter_checker (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.rx_ready_o(rx_ready_o), .carrier_busy_i(carrier_busy_i), .out_valid_o(out_valid_o),
	.out_data_o(out_data_o), .out_last_o(out_last_o), .out_relay_o(out_relay_o), .out_ready_i(out_ready_i));

// file: relay_pkg.sv
/*
 * Shared constants of the repeater relay filter: register offsets, field
 * positions, reset values, operating modes, protocols and header layout.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package relay_pkg;
	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_GROUP = 8'h04;
	localparam logic [7:0] REG_SOURCE = 8'h08;
	localparam logic [7:0] REG_TARGET = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_ACCEPTED = 8'h14;
	localparam logic [7:0] REG_DROPPED = 8'h18;

	// ==========================================================
	// field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_PROTO_LSB = 2;
	localparam int CTRL_HOLD_BIT = 4;
	localparam int STAT_REJECT_BIT = 0;
	localparam int STAT_DEFER_BIT = 1;
	localparam int STAT_BUSY_BIT = 2;

	// ==========================================================
	// operating modes and over-air protocols
	localparam logic [1:0] MODE_DATA = 2'h0;
	localparam logic [1:0] MODE_REPEATER = 2'h1;
	localparam logic [1:0] MODE_TELEMETRY = 2'h2;
	localparam logic [1:0] MODE_POLLED = 2'h3;
	localparam logic [1:0] PROTO_PLAIN = 2'h0;
	localparam logic [1:0] PROTO_FEC = 2'h1;
	localparam logic [1:0] PROTO_PACKET_ARQ = 2'h2;
	localparam logic [1:0] PROTO_SAMPLED = 2'h3;

	// ==========================================================
	// reset values
	localparam logic [1:0] RST_MODE = 2'h0;
	localparam logic [1:0] RST_PROTO = 2'h1;
	localparam logic RST_HOLD = 1'b0;
	localparam logic [7:0] RST_GROUP = 8'h01;
	localparam logic [7:0] RST_SOURCE = 8'h01;
	localparam logic [7:0] RST_TARGET = 8'h00;

	// ==========================================================
	// address values and message header layout
	localparam logic [7:0] UNIT_BROADCAST = 8'hFF;
	localparam logic [7:0] GROUP_OPEN = 8'h00;
	localparam logic [7:0] UNIT_MIN = 8'h01;
	localparam logic [7:0] UNIT_MAX = 8'hFE;
	localparam logic [1:0] HDR_GROUP = 2'h0;
	localparam logic [1:0] HDR_TARGET = 2'h1;
	localparam logic [1:0] HDR_SOURCE = 2'h2;
	localparam logic [1:0] HDR_SEQ = 2'h3;
	localparam logic [2:0] ALARM_CODE_IDX = 3'h4;
endpackage : relay_pkg

// file: stream_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock, synchronous active-high reset, DEPTH at least 2.
 */
module stream_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// filling side
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	// draining side
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	// full and empty from the occupancy count
	assign in_ready_o = (count_r != (AW+1)'(DEPTH));
	assign out_valid_o = (count_r != '0);
	assign out_data_o = mem[rd_ptr_r];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	// storage write
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data_i;
		end
	end

	// pointers and count
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
			end
			if (push & ~pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop & ~push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule : stream_fifo

// file: test_radio_repeater_relay_filter.sv
/*
 * Bench of the relay filter: register tasks, frames through the peer model,
 * expected frames built from the settings written.
 * Assumes package, design, checker and peer model are compiled first.
 */
module test_radio_repeater_relay_filter;
	timeunit 1ns;
	timeprecision 1ns;
	// ====================
	// stimulus and observed signals
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic carrier_busy_i = 1'b0;
	logic alarm_req_i = 1'b0;
	logic [7:0] alarm_code_i = 8'h00;
	logic stall = 1'b0;
	logic [31:0] wb_dat_o, rd;
	logic wb_ack_o, rx_valid_i, rx_last_i, rx_ready_o, out_valid_o, out_last_o, out_relay_o, out_ready_i;
	logic [7:0] rx_data_i, out_data_o;
	logic [9:0] exp_q[$];
	int err_count = 0;
	int total_checks = 0;
	int cycles = 0;

	// 50 MHz clock
	always #10 clk_i = ~clk_i;

	// design and peer modems
	radio_repeater_relay_filter u_radio_repeater_relay_filter (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_valid_i(rx_valid_i),
		.rx_data_i(rx_data_i), .rx_last_i(rx_last_i), .rx_ready_o(rx_ready_o), .carrier_busy_i(carrier_busy_i),
		.alarm_req_i(alarm_req_i), .alarm_code_i(alarm_code_i), .out_valid_o(out_valid_o),
		.out_data_o(out_data_o), .out_last_o(out_last_o), .out_relay_o(out_relay_o), .out_ready_i(out_ready_i));
	peer_model u_peer_model (.clk_i(clk_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .rx_last_o(rx_last_i),
		.rx_ready_i(rx_ready_o), .out_valid_i(out_valid_o), .out_data_i(out_data_o), .out_last_i(out_last_o),
		.out_relay_i(out_relay_o), .out_ready_o(out_ready_i), .stall_i(stall));

	// ====================
	// verdict and end of run
	task automatic wrap_up();
		if (err_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up
	// count one comparison, report a mismatch
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : check
	// one classic cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb
	// read and compare
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		wb(1'b0, a, 32'h0);
		check($sformatf("reg %h", a), rd, {24'h0, e});
	endtask : rc
	// write then read back
	task automatic wrc(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
		wb(1'b1, a, {24'h0, d});
		rc(a, e);
	endtask : wrc
	// frame on air (f[2]), expected out (f[1]) with relay flag f[0]
	task automatic send(input logic [39:0] m, input logic [2:0] f);
		for (int i = 4; i >= 0; i--) begin
			if (f[2]) u_peer_model.tx_q.push_back({i == 0, m[8*i +: 8]});
			if (f[1]) exp_q.push_back({f[0], i == 0, m[8*i +: 8]});
		end
	endtask : send
	// wait for expected bytes, then compare all
	task automatic drain();
		for (int n = 0; n < 600 && u_peer_model.got_q.size() < exp_q.size(); n++) @(posedge clk_i);
		repeat (40) @(posedge clk_i);
		check("count", u_peer_model.got_q.size(), exp_q.size());
		foreach (exp_q[i]) if (i < u_peer_model.got_q.size()) check("byte", u_peer_model.got_q[i], exp_q[i]);
		exp_q.delete();
		u_peer_model.got_q.delete();
	endtask : drain

	// cycle ceiling against hangs
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			wrap_up();
		end
	end

	// ====================
	// test sequence
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		rc(8'h00, {3'h0, relay_pkg::RST_HOLD, relay_pkg::RST_PROTO, relay_pkg::RST_MODE});
		rc(8'h04, relay_pkg::RST_GROUP);
		rc(8'h08, relay_pkg::RST_SOURCE);
		rc(8'h1C, 8'h00);
		// local delivery ignores the channel
		carrier_busy_i <= 1'b1;
		send(40'h00_09_07_01_A1, 3'b110);
		send(40'h01_01_07_02_A2, 3'b110);
		send(40'h01_09_07_03_A3, 3'b100);
		send(40'h01_01_07_02_A4, 3'b100);
		drain();
		carrier_busy_i <= 1'b0;
		// refused settings
		wrc(8'h00, 8'h08, 8'h08);
		wrc(8'h00, 8'h09, 8'h08);
		rc(8'h10, 8'h01);
		wrc(8'h10, 8'h01, 8'h00);
		wrc(8'h00, 8'h05, 8'h05);
		wrc(8'h00, 8'h09, 8'h05);
		wrc(8'h04, 8'h00, 8'h01);
		wrc(8'h04, 8'hFF, 8'h01);
		wrc(8'h04, 8'h05, 8'h05);
		wrc(8'h08, 8'h00, 8'h01);
		wrc(8'h08, 8'hFF, 8'h01);
		wrc(8'h08, 8'hFE, 8'hFE);
		wrc(8'h0C, 8'h33, 8'h33);
		// relay filtering
		send(40'h05_03_17_01_B1, 3'b111);
		send(40'h06_03_17_02_B2, 3'b100);
		send(40'h00_03_17_03_B3, 3'b100);
		send(40'h05_FF_17_04_B4, 3'b111);
		send(40'h05_03_17_01_B5, 3'b100);
		drain();
		rc(8'h14, 8'h04);
		rc(8'h18, 8'h05);
		// busy channel defers, hold-off lifts it
		carrier_busy_i <= 1'b1;
		send(40'h05_03_08_01_C1, 3'b111);
		repeat (40) @(posedge clk_i);
		check("deferred", u_peer_model.got_q.size(), 0);
		rc(8'h10, 8'h07);
		carrier_busy_i <= 1'b0;
		drain();
		wrc(8'h00, 8'h15, 8'h15);
		carrier_busy_i <= 1'b1;
		send(40'h05_03_08_02_C2, 3'b111);
		drain();
		carrier_busy_i <= 1'b0;
		// protocol locked in telemetry mode
		wrc(8'h00, 8'h06, 8'h06);
		wrc(8'h00, 8'h02, 8'h06);
		wrc(8'h00, 8'h03, 8'h07);
		wrc(8'h00, 8'h05, 8'h05);
		// full buffer, then oldest record entry reused
		stall <= 1'b1;
		for (int i = 0; i < 9; i++) send({24'h05_09_02, 8'(i), 8'h5A}, 3'b111);
		repeat (150) @(posedge clk_i);
		check("rx_ready", rx_ready_o, 1'b0);
		stall <= 1'b0;
		send(40'h05_09_02_00_5B, 3'b111);
		send(40'h05_09_02_08_5C, 3'b100);
		drain();
		// own alarm frame
		alarm_code_i <= 8'h5A;
		alarm_req_i <= 1'b1;
		send(40'h05_FF_FE_00_5A, 3'b011);
		@(posedge clk_i);
		alarm_req_i <= 1'b0;
		drain();
		wrap_up();
	end
endmodule : test_radio_repeater_relay_filter
